//--- design/pwr_seq_map.svh
// register map and timing constants for the power-down wake sequencer
`ifndef PWR_SEQ_MAP_SVH
`define PWR_SEQ_MAP_SVH
// ============================================================
// register byte offsets
`define WAKE_INT_CTRL_OFS   16'hff94
`define PWR_MISC_CTRL_OFS   16'hfff1
`define SEQ_STATUS_OFS      16'hff98
// ============================================================
// field positions
`define WAKE_ROUTE_SEL_BIT  7
`define KP_IRQ_EN_BIT       1
`define KP_IRQ_FLAG_BIT     0
`define PWR_DOWN_REQ_BIT    7
// ============================================================
// reset values
`define WAKE_INT_CTRL_RST   8'h00
`define PWR_MISC_CTRL_RST   8'h00
// ============================================================
// timing counts in cpu clock cycles
`define GRACE_CYCLES        32
`define SETTLE_CYCLES       512
`endif

//--- design/pwr_seq_pkg.sv
// types shared by the power-down wake sequencer
package pwr_seq_pkg;
  // ============================================================
  // sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_RUN    = 5'b00001,
    ST_GRACE  = 5'b00010,
    ST_DOWN   = 5'b00100,
    ST_SETTLE = 5'b01000,
    ST_WAKE   = 5'b10000
  } seq_state_e;
endpackage

//--- design/power_down_wake_sequencer.sv
// power-down wake sequencer with ahb-lite register slave
// Function
// R1 - supply or switch on: standby
// R2 - no supply, switch off: converter off
// R3 - standby gates core, clocks, peripherals
// R4 - wait 32 cycles before analog shutdown
// R5 - grace over: oscillator, pll, reference, bias off
// R6 - software uses only the request bit
// R7 - software sets route select first
// R8 - user, card, keypad irqs wake, ored
// R9 - wake restores power and clocks
// R10 - count 512 cycles, then raise wake irq
// R11 - route select steers keypad, card to wake_interrupt_line; code raises the line for them only after a wake from down, never while running
// R12 - reading wake control clears route select
// R13 - request bit overrides per-block power bits
// R14 - settle counter restarts, idle while down
`include "pwr_seq_map.svh"
`timescale 1ns/1ps
`default_nettype none
module power_down_wake_sequencer
  import pwr_seq_pkg::*;
#(
  parameter int GRACE  = `GRACE_CYCLES,
  parameter int SETTLE = `SETTLE_CYCLES
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [15:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // supply and switch state, asynchronous
  input  wire logic        bus_supply,
  input  wire logic        switch_on,
  // wake sources, asynchronous
  input  wire logic [7:0]  user_io_pins,
  input  wire logic        card_irq,
  input  wire logic        keypad_irq,
  // per-block power controls from other registers
  input  wire logic [7:0]  block_power_en,
  // power and clock controls
  output logic             core_clock_en,
  output logic             periph_clock_en,
  output logic             analog_en,
  output logic             converter_en,
  output logic [7:0]       block_power_gated,
  output logic             standby_mode,
  output logic             off_mode,
  // interrupt lines to the cpu
  output logic             wake_interrupt_line,
  output logic             card_irq_out,
  output logic             keypad_irq_out
);
  // ============================================================
  // synchronisers: three stages, change taken when stages 2 and 3 agree
  logic [10:0] sync1_reg, sync2_reg, sync3_reg, filt_reg;
  logic [10:0] raw;
  assign raw = {bus_supply, switch_on, card_irq, keypad_irq, user_io_pins[6:0]};
  logic        usr7_s1_reg, usr7_s2_reg, usr7_s3_reg, usr7_reg;

  // sampling chain
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_reg <= 11'h000;
      sync2_reg <= 11'h000;
      sync3_reg <= 11'h000;
      usr7_s1_reg <= 1'b0;
      usr7_s2_reg <= 1'b0;
      usr7_s3_reg <= 1'b0;
    end else begin
      sync1_reg <= raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      usr7_s1_reg <= user_io_pins[7];
      usr7_s2_reg <= usr7_s1_reg;
      usr7_s3_reg <= usr7_s2_reg;
    end
  end

  // filtered levels: update only on agreement
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      filt_reg <= 11'h000;
      usr7_reg <= 1'b0;
    end else begin
      for (int i = 0; i < 11; i++) begin
        if (sync2_reg[i] == sync3_reg[i]) begin
          filt_reg[i] <= sync3_reg[i];
        end
      end
      if (usr7_s2_reg == usr7_s3_reg) begin
        usr7_reg <= usr7_s3_reg;
      end
    end
  end

  logic       supply_s, sw_on_s, card_s, kp_s;
  logic [7:0] usr_s;
  assign supply_s = filt_reg[10];
  assign sw_on_s  = filt_reg[9];
  assign card_s   = filt_reg[8];
  assign kp_s     = filt_reg[7];
  assign usr_s    = {usr7_reg, filt_reg[6:0]};

  // ============================================================
  // ahb-lite address phase capture
  logic        wr_pend_reg, rd_pend_reg;
  logic [15:0] addr_reg;
  logic        take;
  assign take = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= 16'h0000;
    end else begin
      wr_pend_reg <= take && hwrite;
      rd_pend_reg <= take && !hwrite;
      if (take) begin
        addr_reg <= haddr;
      end
    end
  end

  // zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
    hit = (a[15:2] == ofs[15:2]);
  endfunction

  logic wr_wake, wr_misc, rd_wake;
  assign wr_wake = wr_pend_reg && hit(addr_reg, `WAKE_INT_CTRL_OFS);
  assign wr_misc = wr_pend_reg && hit(addr_reg, `PWR_MISC_CTRL_OFS);
  // read decoded in address phase so the clear lands with the data
  assign rd_wake = take && !hwrite && hit(haddr, `WAKE_INT_CTRL_OFS);

  // ============================================================
  // registers
  logic [7:0]  wake_interrupt_control_reg;
  logic [7:0]  power_misc_control_reg;
  seq_state_e  state_reg;
  logic        wake_route_select;
  logic        power_down_request;
  logic        kp_flag_set;
  assign wake_route_select  = wake_interrupt_control_reg[`WAKE_ROUTE_SEL_BIT];
  assign power_down_request = power_misc_control_reg[`PWR_DOWN_REQ_BIT];

  // keypad flag raised on synchronised keypad level
  assign kp_flag_set = kp_s;

  // wake control register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_interrupt_control_reg <= `WAKE_INT_CTRL_RST;
    end else begin
      if (wr_wake) begin
        wake_interrupt_control_reg[`WAKE_ROUTE_SEL_BIT] <= hwdata[`WAKE_ROUTE_SEL_BIT];
        wake_interrupt_control_reg[`KP_IRQ_EN_BIT]      <= hwdata[`KP_IRQ_EN_BIT];
        if (!kp_flag_set) begin
          wake_interrupt_control_reg[`KP_IRQ_FLAG_BIT] <= hwdata[`KP_IRQ_FLAG_BIT];
        end
      end
      // a read taken behind a write still clears the route bit: both land on the
      // same edge, and the clear is assigned after the write here, so it wins
      if (rd_wake) begin
        wake_interrupt_control_reg[`WAKE_ROUTE_SEL_BIT] <= 1'b0; // R12
      end
      // set wins over a software clear
      if (kp_flag_set) begin
        wake_interrupt_control_reg[`KP_IRQ_FLAG_BIT] <= 1'b1;
      end
    end
  end

  // misc control register; request bit dropped by hardware on wake
  logic wake_event;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      power_misc_control_reg <= `PWR_MISC_CTRL_RST;
    end else if (state_reg == ST_DOWN && wake_event) begin
      power_misc_control_reg[`PWR_DOWN_REQ_BIT] <= 1'b0;
    end else if (wr_misc) begin
      power_misc_control_reg <= {hwdata[7], 5'b0_0000, hwdata[1:0]};
    end
  end

  // ============================================================
  // wake merge: user pins always, keypad and card when routed
  assign wake_event = (|usr_s) || (wake_route_select && (card_s || kp_s)); // R8 R11

  // ============================================================
  // sequencer
  localparam int GW = $clog2(GRACE + 1);
  localparam int SW = $clog2(SETTLE + 1);
  logic [GW-1:0] grace_cnt_reg;
  logic [SW-1:0] settle_cnt_reg;
  logic          off_path_reg;

  // state transitions
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_RUN;
    end else begin
      case (state_reg)
        ST_RUN: begin
          if (power_down_request) state_reg <= ST_GRACE;
        end
        ST_GRACE: begin
          if (grace_cnt_reg == GW'(GRACE - 1)) state_reg <= ST_DOWN; // R4
        end
        ST_DOWN: begin
          if (wake_event) state_reg <= ST_SETTLE; // R9
        end
        ST_SETTLE: begin
          if (settle_cnt_reg == SW'(SETTLE - 1)) state_reg <= ST_WAKE; // R10
        end
        ST_WAKE: begin
          if (rd_wake || !wake_event) state_reg <= ST_RUN;
        end
        default: state_reg <= ST_RUN;
      endcase
    end
  end

  // grace counter, counts only inside the grace window
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      grace_cnt_reg <= '0;
    end else if (state_reg == ST_GRACE) begin
      grace_cnt_reg <= grace_cnt_reg + GW'(1);
    end else begin
      grace_cnt_reg <= '0;
    end
  end

  // settle counter: cleared while down, runs only once clocks restart
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      settle_cnt_reg <= '0;
    end else if (state_reg == ST_SETTLE) begin
      settle_cnt_reg <= settle_cnt_reg + SW'(1);
    end else begin
      settle_cnt_reg <= '0; // R14
    end
  end

  // off or standby decided at the end of the grace window
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      off_path_reg <= 1'b0;
    end else if (state_reg == ST_GRACE) begin
      off_path_reg <= !supply_s && !sw_on_s; // R1 R2
    end
  end

  // ============================================================
  // power and clock outputs, registered
  logic down;
  assign down = (state_reg == ST_DOWN);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_clock_en       <= 1'b1;
      periph_clock_en     <= 1'b1;
      analog_en           <= 1'b1;
      converter_en        <= 1'b1;
      block_power_gated   <= 8'h00;
      standby_mode        <= 1'b0;
      off_mode            <= 1'b0;
      wake_interrupt_line <= 1'b0;
      card_irq_out        <= 1'b0;
      keypad_irq_out      <= 1'b0;
    end else begin
      core_clock_en       <= !down; // R3 R9
      periph_clock_en     <= !down; // R3
      analog_en           <= !down; // R5
      converter_en        <= !(down && off_path_reg); // R2
      // request overrides individual enables until a wake event drops the request bit
      block_power_gated   <= power_down_request ? 8'h00 : block_power_en; // R13
      standby_mode        <= down && !off_path_reg; // R1
      off_mode            <= down && off_path_reg;
      // hold off until settled; pins wake the cpu normally too when running
      wake_interrupt_line <= (state_reg == ST_WAKE) ||
                             (state_reg == ST_RUN && (|usr_s)); // R10 R14
      card_irq_out        <= card_s && !wake_route_select; // R11
      keypad_irq_out      <= kp_s && !wake_route_select &&
                             wake_interrupt_control_reg[`KP_IRQ_EN_BIT];
    end
  end

  // ============================================================
  // read views: a write still in its data phase is forwarded, so a read
  // issued right behind it returns the new value, not the stale one
  logic [7:0] wake_view;
  logic [7:0] misc_view;

  // wake control as the next read must see it
  always_comb begin
    wake_view = wake_interrupt_control_reg;
    if (wr_wake) begin
      wake_view[`WAKE_ROUTE_SEL_BIT] = hwdata[`WAKE_ROUTE_SEL_BIT];
      wake_view[`KP_IRQ_EN_BIT]      = hwdata[`KP_IRQ_EN_BIT];
      if (!kp_flag_set) begin
        wake_view[`KP_IRQ_FLAG_BIT] = hwdata[`KP_IRQ_FLAG_BIT];
      end
    end
  end

  // misc control as the next read must see it; unused bits stay zero
  always_comb begin
    misc_view = power_misc_control_reg;
    if (wr_misc) begin
      misc_view = {hwdata[7], 5'b0_0000, hwdata[1:0]};
    end
  end

  // ============================================================
  // read data, registered in address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      if (hit(haddr, `WAKE_INT_CTRL_OFS)) begin
        hrdata <= {24'h00_0000, wake_view[7], 5'b0_0000, wake_view[1:0]};
      end else if (hit(haddr, `PWR_MISC_CTRL_OFS)) begin
        hrdata <= {24'h00_0000, misc_view};
      end else if (hit(haddr, `SEQ_STATUS_OFS)) begin
        hrdata <= {25'h000_0000, off_path_reg, 1'b0, state_reg};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end
endmodule
`default_nettype wire

//--- verif/wake_source_model.sv
// behavioural model of the external wake interrupt sources
`timescale 1ns/1ps
`default_nettype none
module wake_source_model (
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // command from the bench, kind 0 releases all
  input  wire logic       fire,
  input  wire logic [1:0] kind,
  // sequencer answer
  input  wire logic       wake_interrupt_line,
  // wake sources
  output logic      [7:0] user_io_pins,
  output logic            card_irq,
  output logic            keypad_irq
);
  // a source holds its level until the wake line answers or the bench fires again, as a real pin would
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      user_io_pins <= 8'h00;
      card_irq     <= 1'b0;
      keypad_irq   <= 1'b0;
    end else if (fire || wake_interrupt_line) begin
      user_io_pins <= (fire && kind == 2'd1) ? 8'h08 : 8'h00;
      card_irq     <= fire && kind == 2'd2;
      keypad_irq   <= fire && kind == 2'd3;
    end
  end
endmodule
`default_nettype wire

//--- verif/pwr_seq_properties.sv
// port assertions for the power-down wake sequencer
`include "pwr_seq_map.svh"
`timescale 1ns/1ps
`default_nettype none
module pwr_seq_properties #(
  parameter int GRACE  = `GRACE_CYCLES,
  parameter int SETTLE = `SETTLE_CYCLES
) (
  // clock, reset and bus request
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [15:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  // supply, power controls and wake line
  input wire logic        bus_supply,
  input wire logic        switch_on,
  input wire logic        core_clock_en,
  input wire logic        periph_clock_en,
  input wire logic        analog_en,
  input wire logic        converter_en,
  input wire logic [7:0]  block_power_gated,
  input wire logic        standby_mode,
  input wire logic        off_mode,
  input wire logic        wake_interrupt_line
);
  localparam int GMAX = GRACE + 4;
  localparam int SMIN = SETTLE - 2;
  localparam int SMAX = SETTLE + 4;
  logic        aw_q;
  logic        an_q;
  logic        settling;
  logic [7:0]  since_req;
  logic [10:0] up_cnt;
  logic [31:0] src_hist;
  wire         req_pulse = aw_q && hready && hwdata[`PWR_DOWN_REQ_BIT];
  wire         rise_an   = analog_en && !an_q;
  // ============================================================
  // helper: request landing, grace age, settle age, supply history
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aw_q      <= 1'b0;
      an_q      <= 1'b1;
      settling  <= 1'b0;
      since_req <= 8'hff;
      up_cnt    <= 11'h000;
      src_hist  <= 32'h0000_0000;
    end else begin
      if (hready) aw_q <= hsel && htrans[1] && hwrite && haddr == `PWR_MISC_CTRL_OFS;
      an_q      <= analog_en;
      settling  <= rise_an || (settling && !wake_interrupt_line);
      since_req <= req_pulse ? 8'h00 : since_req + {7'h00, since_req != 8'hff};
      up_cnt    <= rise_an ? 11'h000 : up_cnt + {10'h000, settling && up_cnt != 11'h7ff};
      src_hist  <= {src_hist[30:0], bus_supply || switch_on};
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_req_written; req_pulse; endsequence
  sequence s_down; $fell(analog_en); endsequence
  property p_grace_min; s_down |-> since_req >= GRACE; endproperty
  property p_grace_max; s_req_written |-> ##[GRACE:GMAX] !analog_en; endproperty
  property p_gate; core_clock_en == analog_en && periph_clock_en == analog_en; endproperty
  property p_standby; s_down and (&src_hist) |=> converter_en && standby_mode && !off_mode;
  endproperty
  property p_off; s_down and !(|src_hist) |=> !converter_en && off_mode && !standby_mode;
  endproperty
  property p_override; s_req_written |-> ##2 block_power_gated == 8'h00; endproperty
  property p_quiet_down; !analog_en |-> !wake_interrupt_line; endproperty
  property p_settle_min; settling && up_cnt < SMIN |-> !wake_interrupt_line; endproperty
  property p_settle_max; $rose(analog_en) |-> ##[SMIN:SMAX] wake_interrupt_line; endproperty
  a_grace_min: assert property (p_grace_min) else $error("analog off before grace");
  a_grace_max: assert property (p_grace_max) else $error("analog not off after grace");
  a_gate: assert property (p_gate) else $error("clock gates disagree with analog");
  a_standby: assert property (p_standby) else $error("standby not entered");
  a_off: assert property (p_off) else $error("off mode not entered");
  a_override: assert property (p_override) else $error("block power not gated");
  a_quiet_down: assert property (p_quiet_down) else $error("wake line while down");
  a_settle_min: assert property (p_settle_min) else $error("wake line too early");
  a_settle_max: assert property (p_settle_max) else $error("wake line too late");
endmodule
bind power_down_wake_sequencer pwr_seq_properties #(.GRACE(GRACE), .SETTLE(SETTLE)) u_props (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata, .bus_supply,
  .switch_on, .core_clock_en, .periph_clock_en, .analog_en, .converter_en,
  .block_power_gated, .standby_mode, .off_mode, .wake_interrupt_line
);
`default_nettype wire

//--- verif/testbench.sv
// self-checking bench for the power-down wake sequencer
`include "pwr_seq_map.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        hclk, hresetn, hsel, hwrite, fire, hreadyout, hresp;
  logic [1:0]  htrans, kind;
  logic [2:0]  hsize;
  logic [15:0] haddr;
  logic [31:0] hwdata, hrdata;
  logic        bus_supply, switch_on, card_irq, keypad_irq, card_irq_out, keypad_irq_out;
  logic [7:0]  user_io_pins, block_power_en, block_power_gated;
  logic        core_clock_en, periph_clock_en, analog_en, converter_en;
  logic        standby_mode, off_mode, wake_interrupt_line;
  int          errors, checked;
  power_down_wake_sequencer #(.GRACE(32), .SETTLE(512)) u_dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready(hreadyout), .hwdata,
    .hrdata, .hreadyout, .hresp, .bus_supply, .switch_on, .user_io_pins, .card_irq,
    .keypad_irq, .block_power_en, .core_clock_en, .periph_clock_en, .analog_en,
    .converter_en, .block_power_gated, .standby_mode, .off_mode, .wake_interrupt_line,
    .card_irq_out, .keypad_irq_out
  );
  wake_source_model u_src (
    .hclk, .hresetn, .fire, .kind, .wake_interrupt_line, .user_io_pins, .card_irq,
    .keypad_irq
  );
  // ============================================================
  // clock and watchdog, a full run needs about 1800 cycles
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial begin
    #200_000;
    errors++;
    complete_run();
  end
  // ============================================================
  // bus and compare tasks
  task automatic complete_run();
    if (errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      errors++;
    end
  endtask
  // address phase held until hready, then data phase held until hready again
  task automatic ahb(input logic wr, input logic [15:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask
  task automatic rd_chk(input string nm, input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0000_0000, x);
    chk(nm, exp, x);
  endtask
  task automatic fire_src(input logic [1:0] k);
    kind <= k;
    fire <= 1'b1;
    @(posedge hclk);
    fire <= 1'b0;
    @(posedge hclk);
  endtask
  // one full power-down and wake with a chosen source and supply state
  task automatic power_cycle(input logic [1:0] k, input logic bs, input logic sw);
    int n;
    bus_supply <= bs;
    switch_on  <= sw;
    wr(`WAKE_INT_CTRL_OFS, 32'h0000_0082);
    wr(`PWR_MISC_CTRL_OFS, 32'h0000_0080);
    repeat (28) @(posedge hclk);
    chk("grace analog", 1, analog_en);
    for (n = 0; n < 20 && analog_en !== 1'b0; n++) @(posedge hclk);
    repeat (2) @(posedge hclk);
    chk("core clock", 0, core_clock_en);
    chk("gated", 0, block_power_gated);
    chk("converter", bs | sw, converter_en);
    chk("off mode", !(bs | sw), off_mode);
    chk("standby", bs | sw, standby_mode);
    chk("periph clock", 0, periph_clock_en);
    fire_src(k);
    for (n = 0; n < 100 && analog_en !== 1'b1; n++) @(posedge hclk);
    for (n = 0; n < 700 && wake_interrupt_line !== 1'b1; n++) @(posedge hclk);
    chk("settle span", 1, n >= `SETTLE_CYCLES - 8 && n <= `SETTLE_CYCLES + 8);
    chk("clocks back", 1, core_clock_en && converter_en);
    rd_chk("request cleared", `PWR_MISC_CTRL_OFS, 32'h0000_0000);
    rd_chk("route first", `WAKE_INT_CTRL_OFS, {31'h41, k == 2'd3});
    rd_chk("route cleared", `WAKE_INT_CTRL_OFS, {31'h01, k == 2'd3});
    chk("okay response", 0, hresp);
    rd_chk("status", `SEQ_STATUS_OFS, {25'h000_0000, !(bs | sw), 6'h01});
  endtask
  // ============================================================
  // main sequence
  initial begin
    {hsel, hwrite, fire, hresetn, switch_on} = 5'b00000;
    {htrans, kind, haddr, hwdata} = '0;
    hsize = 3'b010;
    bus_supply = 1'b1;
    block_power_en = 8'ha5;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk("wake ctrl reset", `WAKE_INT_CTRL_OFS, 32'h0000_0000);
    rd_chk("misc reset", `PWR_MISC_CTRL_OFS, 32'h0000_0000);
    rd_chk("unmapped", 16'hff00, 32'h0000_0000);
    chk("block copy", 8'ha5, block_power_gated);
    wr(`WAKE_INT_CTRL_OFS, 32'h0000_0002);
    fire_src(2'd2);
    repeat (8) @(posedge hclk);
    chk("card normal", 1, card_irq_out);
    wr(`WAKE_INT_CTRL_OFS, 32'h0000_0082);
    repeat (4) @(posedge hclk);
    chk("card steered", 0, card_irq_out);
    fire_src(2'd3);
    wr(`WAKE_INT_CTRL_OFS, 32'h0000_0002);
    repeat (8) @(posedge hclk);
    chk("keypad normal", 1, keypad_irq_out);
    fire_src(2'd1);
    repeat (8) @(posedge hclk);
    chk("user pin line", 1, wake_interrupt_line);
    fire_src(2'd0);
    power_cycle(2'd2, 1'b1, 1'b0);
    power_cycle(2'd3, 1'b0, 1'b0);
    power_cycle(2'd1, 1'b0, 1'b1);
    complete_run();
  end
endmodule
`default_nettype wire
